// >>> pkg/sffe_consts.svh
`ifndef SFFE_CONSTS_SVH
`define SFFE_CONSTS_SVH
`define SFFE_OP_DUAL_OUT 8'h3B
`define SFFE_OP_DUAL_IO 8'hBB
`define SFFE_OP_QUAD_OUT 8'h6B
`define SFFE_OP_QUAD_IO 8'hEB
`define SFFE_OP_QUAD_WORD 8'hE7
`define SFFE_OP_QUAD_OCTAL 8'hE3
`define SFFE_OPCODE_BITS 4'h8
`define SFFE_CNT_RST 6'h00
`define SFFE_SR_RST 8'h00
`endif

// >>> pkg/sffe_pkg.sv
package sffe_pkg;
    typedef enum logic [1:0] {
        SFFE_W1,
        SFFE_W2,
        SFFE_W4
    } sffe_width_t;
    typedef enum logic [1:0] {
        SFFE_ST_IDLE,
        SFFE_ST_OPCODE,
        SFFE_ST_BODY
    } sffe_state_t;
    typedef struct packed {
        logic [3:0] data;
        logic [3:0] oe_b;
    } sffe_lines_t;
    typedef struct packed {
        logic valid;
        logic [7:0] value;
    } sffe_byte_t;
endpackage : sffe_pkg

// >>> design/sffe_front_end.sv
// Functional notes
// - Chip select high deselects; all data lines released.
// - Chip select low selects device for instruction input and data output.
// - Internal busy cycle keeps running after chip select rises.
// - No instruction accepted until chip select falls after power-up; a select held low through reset is still accepted.
// - Single-line mode samples serial_in on rising serial clock.
// - Single-line mode drives output line, changing on falling edges.
// - Dual and quad modes capture on rising, drive on falling edges.
// - SPI modes 0 and 3 both supported.
// - Opcodes 3B and BB use data lines 0 and 1.
// - Opcodes 6B, EB, E7, E3 use data lines 0 to 3.
// - Quad opcodes only accepted with quad_enable_bit set.
// - Write-protect is active low, disabled while quad enabled.
// - Pause only in single and dual operation.
// - Pause starts at pause fall if clock low, else next falling edge.
// - Pause ends at pause rise if clock low, else next falling edge.
// - During pause output released, input and clock ignored.
// - Pause keeps instruction state and buffered data.
`timescale 1ns/10ps
`include "sffe_consts.svh"
module sffe_front_end (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Serial pins
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic [3:0] data_line_i,
    output sffe_pkg::sffe_lines_t data_line_o,
    // Configuration and core status
    input wire logic quad_enable_bit_i,
    input wire logic busy_i,
    // Core side
    output sffe_pkg::sffe_byte_t opcode_o,
    output sffe_pkg::sffe_byte_t rx_byte_o,
    input wire logic [7:0] tx_byte_i,
    output logic tx_load_o,
    input wire logic [1:0] xfer_width_i,
    input wire logic xfer_dir_out_i,
    output logic selected_o,
    output logic paused_o,
    output logic status_write_ok_o,
    output logic busy_o
);
    // Two-stage synchronisers
    logic [6:0] meta_q;
    logic [6:0] meta_d;
    logic [6:0] sync_q;
    logic [6:0] sync_d;
    logic wp_ok_q;
    logic wp_ok_d;
    logic sclk_prev_q;
    logic sclk_prev_d;
    logic hold_prev_q;
    logic hold_prev_d;
    logic armed_q;
    logic armed_d;
    logic pause_q;
    logic pause_d;
    sffe_pkg::sffe_state_t state_q;
    sffe_pkg::sffe_state_t state_d;
    sffe_pkg::sffe_width_t width_q;
    sffe_pkg::sffe_width_t width_d;
    logic [7:0] shreg_q;
    logic [7:0] shreg_d;
    logic [3:0] bits_q;
    logic [3:0] bits_d;
    logic [7:0] txsh_q;
    logic [7:0] txsh_d;
    logic [3:0] txbits_q;
    logic [3:0] txbits_d;
    logic out_en_q;
    logic out_en_d;
    sffe_pkg::sffe_lines_t lines_q;
    sffe_pkg::sffe_lines_t lines_d;
    sffe_pkg::sffe_byte_t op_q;
    sffe_pkg::sffe_byte_t op_d;
    sffe_pkg::sffe_byte_t rx_q;
    sffe_pkg::sffe_byte_t rx_d;
    logic tx_load_q;
    logic tx_load_d;

    logic s_sclk;
    logic s_cs_b;
    logic s_qe;
    logic [3:0] s_io;
    logic rise;
    logic fall;
    logic [3:0] step;

    function automatic sffe_pkg::sffe_width_t op_width(input logic [7:0] op, input logic qe);
        sffe_pkg::sffe_width_t w;
        w = sffe_pkg::SFFE_W1;
        if (op == `SFFE_OP_DUAL_OUT || op == `SFFE_OP_DUAL_IO)
            w = sffe_pkg::SFFE_W2;
        else if (qe && (op == `SFFE_OP_QUAD_OUT || op == `SFFE_OP_QUAD_IO
                 || op == `SFFE_OP_QUAD_WORD || op == `SFFE_OP_QUAD_OCTAL))
            w = sffe_pkg::SFFE_W4;
        return w;
    endfunction : op_width

    function automatic logic [3:0] width_step(input sffe_pkg::sffe_width_t w);
        logic [3:0] s;
        unique case (w)
            sffe_pkg::SFFE_W1: s = 4'h1;
            sffe_pkg::SFFE_W2: s = 4'h2;
            sffe_pkg::SFFE_W4: s = 4'h4;
            default: s = 4'h1;
        endcase
        return s;
    endfunction : width_step

    // Core may widen a single-line body to dual; quad comes only from the opcode
    function automatic sffe_pkg::sffe_width_t req_width(input sffe_pkg::sffe_width_t cur,
        input logic [1:0] req);
        sffe_pkg::sffe_width_t w;
        w = cur;
        if (req == 2'h1 && cur == sffe_pkg::SFFE_W1)
            w = sffe_pkg::SFFE_W2;
        return w;
    endfunction : req_width

    always_comb
    begin
        // Quad enable, data lines, select, clock
        meta_d = {quad_enable_bit_i, data_line_i, cs_b_i, sclk_i};
        sync_d = meta_q;
        wp_ok_d = s_qe || s_io[2];
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            // Pins rest at idle levels, quad enable off
            meta_q <= 7'h3E;
            sync_q <= 7'h3E;
            wp_ok_q <= 1'b1;
        end
        else if (clk_en_i)
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            wp_ok_q <= wp_ok_d;
        end
    end

    assign s_sclk = sync_q[0];
    assign s_cs_b = sync_q[1];
    assign s_io = sync_q[5:2];
    assign s_qe = sync_q[6];
    assign rise = s_sclk && !sclk_prev_q;
    assign fall = !s_sclk && sclk_prev_q;
    assign step = width_step(width_q);

    // Pause tracking; never while quad lines are in use
    always_comb
    begin
        hold_prev_d = s_io[3];
        pause_d = pause_q;
        if (s_cs_b)
            pause_d = 1'b0;
        else if (width_q == sffe_pkg::SFFE_W4)
            pause_d = 1'b0;
        else if (!pause_q && !s_io[3] && (fall || (!s_sclk && hold_prev_q)))
            pause_d = 1'b1;
        else if (pause_q && s_io[3] && (fall || (!s_sclk && !hold_prev_q)))
            pause_d = 1'b0;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            hold_prev_q <= 1'b1;
            pause_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            hold_prev_q <= hold_prev_d;
            pause_q <= pause_d;
        end
    end

    always_comb
    begin
        sclk_prev_d = s_sclk;
        armed_d = armed_q;
        state_d = state_q;
        width_d = width_q;
        shreg_d = shreg_q;
        bits_d = bits_q;
        txsh_d = txsh_q;
        txbits_d = txbits_q;
        out_en_d = out_en_q;
        lines_d = lines_q;
        op_d = op_q;
        op_d.valid = 1'b0;
        rx_d = rx_q;
        rx_d.valid = 1'b0;
        tx_load_d = 1'b0;
        if (s_cs_b)
        begin
            armed_d = 1'b1;
            state_d = sffe_pkg::SFFE_ST_IDLE;
            width_d = sffe_pkg::SFFE_W1;
            bits_d = 4'h0;
            txbits_d = 4'h0;
            out_en_d = 1'b0;
            lines_d.oe_b = 4'hF;
        end
        else
        begin
            if (armed_q && state_q == sffe_pkg::SFFE_ST_IDLE)
            begin
                state_d = sffe_pkg::SFFE_ST_OPCODE;
                armed_d = 1'b0;
            end
            // Released while paused; shift state is kept
            if (pause_q)
                lines_d.oe_b = 4'hF;
            else
            begin
                if (rise && state_q != sffe_pkg::SFFE_ST_IDLE)
                begin
                    unique case (width_q)
                        sffe_pkg::SFFE_W1: shreg_d = {shreg_q[6:0], s_io[0]};
                        sffe_pkg::SFFE_W2: shreg_d = {shreg_q[5:0], s_io[1:0]};
                        sffe_pkg::SFFE_W4: shreg_d = {shreg_q[3:0], s_io[3:0]};
                        default: shreg_d = shreg_q;
                    endcase
                    bits_d = bits_q + step;
                    if (bits_d >= `SFFE_OPCODE_BITS)
                    begin
                        bits_d = 4'h0;
                        if (state_q == sffe_pkg::SFFE_ST_OPCODE)
                        begin
                            op_d.valid = 1'b1;
                            op_d.value = shreg_d;
                            width_d = op_width(shreg_d, s_qe);
                            state_d = sffe_pkg::SFFE_ST_BODY;
                        end
                        else if (!xfer_dir_out_i)
                        begin
                            rx_d.valid = 1'b1;
                            rx_d.value = shreg_d;
                        end
                    end
                    // First body rise arms output; the next fall drives bit 7
                    if (state_q == sffe_pkg::SFFE_ST_BODY && xfer_dir_out_i)
                        out_en_d = 1'b1;
                end
                if (state_q == sffe_pkg::SFFE_ST_BODY)
                    width_d = req_width(width_q, xfer_width_i);
                if (fall && out_en_q && xfer_dir_out_i)
                begin
                    // New byte taken at the first fall of each byte
                    if (txbits_q == 4'h0)
                    begin
                        txsh_d = tx_byte_i;
                        tx_load_d = 1'b1;
                    end
                    else
                        txsh_d = txsh_q;
                    unique case (width_q)
                        sffe_pkg::SFFE_W1:
                        begin
                            lines_d.data = {2'h0, txsh_d[7], 1'b0};
                            lines_d.oe_b = 4'hD;
                            txsh_d = {txsh_d[6:0], 1'b0};
                        end
                        sffe_pkg::SFFE_W2:
                        begin
                            lines_d.data = {2'h0, txsh_d[7:6]};
                            lines_d.oe_b = 4'hC;
                            txsh_d = {txsh_d[5:0], 2'h0};
                        end
                        sffe_pkg::SFFE_W4:
                        begin
                            lines_d.data = txsh_d[7:4];
                            lines_d.oe_b = 4'h0;
                            txsh_d = {txsh_d[3:0], 4'h0};
                        end
                        default: lines_d = lines_q;
                    endcase
                    txbits_d = txbits_q + step;
                    if (txbits_d >= `SFFE_OPCODE_BITS)
                        txbits_d = 4'h0;
                end
                if (!xfer_dir_out_i && state_q == sffe_pkg::SFFE_ST_BODY)
                    lines_d.oe_b = 4'hF;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sclk_prev_q <= 1'b0;
            armed_q <= 1'b0;
            state_q <= sffe_pkg::SFFE_ST_IDLE;
            width_q <= sffe_pkg::SFFE_W1;
            shreg_q <= `SFFE_SR_RST;
            bits_q <= 4'h0;
            txsh_q <= `SFFE_SR_RST;
            txbits_q <= 4'h0;
            out_en_q <= 1'b0;
            lines_q <= {4'h0, 4'hF};
            op_q <= '0;
            rx_q <= '0;
            tx_load_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            sclk_prev_q <= sclk_prev_d;
            armed_q <= armed_d;
            state_q <= state_d;
            width_q <= width_d;
            shreg_q <= shreg_d;
            bits_q <= bits_d;
            txsh_q <= txsh_d;
            txbits_q <= txbits_d;
            out_en_q <= out_en_d;
            lines_q <= lines_d;
            op_q <= op_d;
            rx_q <= rx_d;
            tx_load_q <= tx_load_d;
        end
    end

    assign data_line_o = lines_q;
    assign opcode_o = op_q;
    assign rx_byte_o = rx_q;
    assign tx_load_o = tx_load_q;
    assign selected_o = !s_cs_b;
    assign paused_o = pause_q;
    // Protect pin ignored once quad lines are enabled
    assign status_write_ok_o = wp_ok_q;
    // Core busy passes through regardless of select
    assign busy_o = busy_i;
endmodule : sffe_front_end

// >>> test/sffe_front_end_checker.sv
`timescale 1ns/10ps
module sffe_front_end_checker (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Serial pins
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic [3:0] data_line_i,
    input wire sffe_pkg::sffe_lines_t data_line_o,
    // Configuration, status and core side
    input wire logic quad_enable_bit_i,
    input wire logic busy_i,
    input wire sffe_pkg::sffe_byte_t opcode_o,
    input wire sffe_pkg::sffe_byte_t rx_byte_o,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_load_o,
    input wire logic [1:0] xfer_width_i,
    input wire logic xfer_dir_out_i,
    input wire logic selected_o,
    input wire logic paused_o,
    input wire logic status_write_ok_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence s_cs_idle;
        cs_b_i [*4];
    endsequence
    sequence s_cs_fall;
        $fell(cs_b_i) ##1 !cs_b_i [*3];
    endsequence
    a_busy_pass: assert property (busy_o == busy_i)
        else $error("busy output not following busy input");
    a_select_on: assert property (s_cs_fall |-> selected_o)
        else $error("select low did not select");
    a_idle_float: assert property (s_cs_idle |-> !selected_o && &data_line_o.oe_b)
        else $error("deselected device still driving");
    a_idle_no_pause: assert property (s_cs_idle |-> !paused_o)
        else $error("pause kept while deselected");
    a_op_pulse: assert property (opcode_o.valid |=> !opcode_o.valid)
        else $error("opcode valid longer than one cycle");
    a_qe_status: assert property (quad_enable_bit_i [*4] |-> status_write_ok_o)
        else $error("protect pin active with quad enabled");
    a_wp_lock: assert property ((!quad_enable_bit_i && !data_line_i[2]) [*4] |->
        !status_write_ok_o)
        else $error("status write allowed with protect low");
    a_pause_float: assert property (paused_o [*2] |-> &data_line_o.oe_b)
        else $error("line driven during pause");
endmodule : sffe_front_end_checker

bind sffe_front_end sffe_front_end_checker u_chk (.*);

// >>> test/sffe_master_model.sv
`timescale 1ns/10ps
module sffe_master_model (
    // System clock
    input wire logic clock_i,
    // Serial pins
    output logic sclk_o,
    output logic cs_b_o,
    output logic [3:0] drive_o
);
    initial sclk_o = 1'b0;
    initial cs_b_o = 1'b1;
    // Protect and pause pins rest high
    initial drive_o = 4'hC;
    // Pin changes now; one edge passes before the next strobe
    task automatic set_line(input int k, input logic v);
        drive_o[k] <= v;
        @(posedge clock_i);
    endtask : set_line
    // Clock rests at the mode's level on both select edges
    task automatic frame(input logic mode3, input logic sel_b);
        @(posedge clock_i);
        sclk_o <= mode3;
        repeat (4) @(posedge clock_i);
        cs_b_o <= sel_b;
        repeat (4) @(posedge clock_i);
    endtask : frame
    // MSB first, data changes while the clock is low
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--)
        begin
            sclk_o <= 1'b0;
            drive_o[0] <= b[i];
            repeat (4) @(posedge clock_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clock_i);
        end
    endtask : send_bits
endmodule : sffe_master_model

// >>> test/serial_flash_spi_front_end_tb.sv
`timescale 1ns/10ps
`include "sffe_consts.svh"
module serial_flash_spi_front_end_tb;
    logic clock_i = 1'b0, rst_b_i = 1'b0, tgl = 1'b0;
    logic quad_enable_bit_i = 1'b0, busy_i = 1'b0;
    logic sclk_i, cs_b_i, selected_o, paused_o, status_write_ok_o, busy_o;
    logic [3:0] mst, data_line_i;
    logic [7:0] got_op;
    logic dir_out = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    int num_errors = 0, compares = 0;
    sffe_pkg::sffe_lines_t data_line_o;
    sffe_pkg::sffe_byte_t opcode_o;
    always #20 clock_i = ~clock_i;
    always @(posedge clock_i) tgl <= ~tgl;
    always @(posedge clock_i) if (opcode_o.valid === 1'b1) got_op <= opcode_o.value;
    // Released line 1 shows a changing pattern
    assign data_line_i = (~data_line_o.oe_b & data_line_o.data) |
        (data_line_o.oe_b & {mst[3:2], tgl, mst[0]});
    sffe_master_model u_mst (
        .clock_i(clock_i),
        .sclk_o(sclk_i),
        .cs_b_o(cs_b_i),
        .drive_o(mst)
    );
    sffe_front_end u_dut (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(1'b1),
        .sclk_i(sclk_i),
        .cs_b_i(cs_b_i),
        .data_line_i(data_line_i),
        .data_line_o(data_line_o),
        .quad_enable_bit_i(quad_enable_bit_i),
        .busy_i(busy_i),
        .opcode_o(opcode_o),
        .rx_byte_o(),
        .tx_byte_i(tx_byte),
        .tx_load_o(),
        .xfer_width_i(2'h0),
        .xfer_dir_out_i(dir_out),
        .selected_o(selected_o),
        .paused_o(paused_o),
        .status_write_ok_o(status_write_ok_o),
        .busy_o(busy_o)
    );
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) num_errors++;
        if (got !== exp) $display("[FAIL] %s exp %h got %h", what, exp, got);
    endtask : check
    task automatic wrap_up();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic t_frame(input logic [7:0] code, input logic mode3);
        got_op = ~code;
        u_mst.frame(mode3, 1'b0);
        u_mst.send_bits(code, 8);
        u_mst.frame(mode3, 1'b1);
        check("opcode", code, got_op);
    endtask : t_frame
    task automatic t_codes();
        logic [7:0] codes [6] = '{`SFFE_OP_DUAL_OUT, `SFFE_OP_DUAL_IO, `SFFE_OP_QUAD_OUT,
            `SFFE_OP_QUAD_IO, `SFFE_OP_QUAD_WORD, `SFFE_OP_QUAD_OCTAL};
        foreach (codes[i]) t_frame(codes[i], i[0]);
    endtask : t_codes
    // Single-line read: one lead-in clock, then eight bits on line 1
    task automatic t_read();
        logic [7:0] seen;
        seen = 8'h00;
        tx_byte <= 8'hC3;
        u_mst.frame(1'b0, 1'b0);
        u_mst.send_bits(8'h5A, 8);
        dir_out <= 1'b1;
        u_mst.send_bits(8'h00, 1);
        for (int i = 0; i < 8; i++)
        begin
            u_mst.send_bits(8'h00, 1);
            seen = {seen[6:0], data_line_o.data[1]};
            check("line 1 driven", 8'h00, {7'h00, data_line_o.oe_b[1]});
        end
        u_mst.frame(1'b0, 1'b1);
        dir_out <= 1'b0;
        check("read byte", 8'hC3, seen);
    endtask : t_read
    // Pause in mid-opcode; clocked bits during it must be lost
    task automatic t_pause();
        u_mst.frame(1'b0, 1'b0);
        u_mst.send_bits(8'hA5, 4);
        u_mst.set_line(3, 1'b0);
        u_mst.send_bits(8'h00, 2);
        check("paused", 8'h01, {7'h00, paused_o});
        u_mst.set_line(3, 1'b1);
        u_mst.send_bits(8'h50, 4);
        u_mst.frame(1'b0, 1'b1);
        check("resumed opcode", 8'hA5, got_op);
    endtask : t_pause
    task automatic t_status();
        for (int i = 0; i < 4; i++)
        begin
            u_mst.set_line(2, i[0]);
            quad_enable_bit_i <= i[1];
            busy_i <= i[0];
            repeat (5) @(posedge clock_i);
            check("write ok", {7'h00, i[1] | i[0]}, {7'h00, status_write_ok_o});
            check("busy", {7'h00, i[0]}, {7'h00, busy_o});
        end
    endtask : t_status
    initial
    begin
        repeat (8) @(posedge clock_i);
        rst_b_i <= 1'b1;
        check("lines after reset", 8'h0F, {4'h0, data_line_o.oe_b});
        t_pause();
        t_status();
        t_codes();
        t_read();
        wrap_up();
    end
    initial
    begin
        repeat (20000) @(posedge clock_i);
        num_errors++;
        wrap_up();
    end
endmodule : serial_flash_spi_front_end_tb
